// [rtl/status_sender.sv]
// sending end: steps message cycles, samples status pairs, decides outcome
// assumes one receiver end and the bench resolving the shared lines
//
// Summary of operation
// R1: status cycles sample two-bit flag pairs
// R2: mode and focus choose pair meaning
// R3: eoi accept updates at 13, 14 cycles
// R4: eoi retry updates at 13, resends
// R5: eoi errors: no update, 14, resend
// R6: short accept updates at 20, 21 cycles
// R7: short retry updates at 20, resends
// R8: short or lowest errors: no update, 21
// R9: lowest no-focus do-lowest runs 34 cycles
// R10: bad win pair still updates, resends
// R11: no-focus end-and-retry updates, 34, resends
// R12: no-focus acceptance upper bit 0 errors
// R13: lowest focus status updates at 20
// R14: checksum mismatch drives 11, ignore message
// R15: focus processor drives 10 at cycle 19
// R16: only winner drives cycle 33; error resends
`timescale 1ns/1ps
module status_sender (
    input  wire logic   sys_clk,    // 50 MHz clock
    input  wire logic   resetn,     // synchronous reset, active low
    input  wire logic   start,      // begin a message, pulse
    input  wire logic   eoi,        // message is end-of-interrupt
    input  wire logic [2:0] mode,   // delivery mode of message
    status_bus_if.sender bus,       // status bus
    output logic        busy,       // message in progress
    output logic        done,       // outcome valid, pulse
    output logic        resend,     // sender must resend
    output logic        arb_update, // arbitration identifier updated, pulse
    output logic [5:0]  msg_length  // final message length
);

    typedef struct packed {
        logic       busy;
        logic       eoi;
        logic [2:0] mode;
        logic [5:0] cycle;
        logic [1:0] cs;
        logic [1:0] acc;
        logic       upd_ok;
        logic       done;
        logic       resend;
        logic       arb_update;
        logic [5:0] length;
    } state_t;

    state_t s_r, s_nxt;
    logic [5:0] cs_cyc, acc_cyc, end_cyc;
    logic       lowest;

    // ------------------------------------------------------------------
    // decode of status pairs
    // ------------------------------------------------------------------
    // cycle numbers follow the message kind; lowest priority may extend
    always_comb begin
        lowest  = !s_r.eoi && (s_r.mode == 3'(bus_status_pkg::DM_LOWEST));
        cs_cyc  = s_r.eoi ? bus_status_pkg::EOI_CS_CYCLE : bus_status_pkg::SHORT_CS_CYCLE;
        acc_cyc = s_r.eoi ? bus_status_pkg::EOI_ACC_CYCLE : bus_status_pkg::SHORT_ACC_CYCLE;
        end_cyc = s_r.eoi ? bus_status_pkg::EOI_LENGTH : bus_status_pkg::SHORT_LENGTH;
        s_nxt            = s_r;
        s_nxt.done       = 1'b0;
        s_nxt.arb_update = 1'b0;
        if (!s_r.busy) begin
            if (start) begin
                s_nxt.busy  = 1'b1;
                s_nxt.eoi   = eoi;
                s_nxt.mode  = mode;
                s_nxt.cycle = 6'h01;
            end
        end else begin
            s_nxt.cycle = s_r.cycle + 6'h01;
            if (s_r.cycle == cs_cyc) begin
                s_nxt.cs = bus.line_in; // [R1]
            end
            if (s_r.cycle == acc_cyc) begin
                s_nxt.acc = bus.line_in; // [R1]
                // update decision taken here, pulsed at the update cycle [R2]
                if (s_r.cs == bus_status_pkg::ST_OK && bus.line_in[1]) begin
                    s_nxt.arb_update = 1'b1; // [R3] [R4] [R6] [R7] [R9] [R11]
                end else if (lowest && s_r.cs == bus_status_pkg::ST_FOCUS) begin
                    s_nxt.arb_update = 1'b1; // [R13]
                end
            end
            if (s_r.cycle == end_cyc && !(lowest && s_r.cs != bus_status_pkg::ST_ERROR
                    && s_r.cs[1] == s_r.cs[0] || lowest && s_r.cs == bus_status_pkg::ST_FOCUS)) begin
                // eoi, short and lowest messages without an ok or focus checksum end here [R3] [R5] [R6] [R8]
                s_nxt.busy   = 1'b0;
                s_nxt.done   = 1'b1;
                s_nxt.length = end_cyc;
                s_nxt.resend = !(s_r.cs == bus_status_pkg::ST_OK
                                 && s_r.acc == bus_status_pkg::ST_ACCEPT); // [R4] [R7] [R8]
            end
            if (s_r.cycle == bus_status_pkg::LOWEST_WIN_CYCLE) begin
                s_nxt.upd_ok = (bus.line_in == bus_status_pkg::ST_ACCEPT); // [R10] [R16]
            end
            if (s_r.cycle == bus_status_pkg::LOWEST_LENGTH) begin
                s_nxt.busy   = 1'b0;
                s_nxt.done   = 1'b1;
                s_nxt.length = bus_status_pkg::LOWEST_LENGTH;
                if (s_r.cs == bus_status_pkg::ST_FOCUS) begin
                    s_nxt.resend = 1'b0; // [R13]
                end else if (s_r.acc == bus_status_pkg::ST_RETRY) begin
                    s_nxt.resend = !s_r.upd_ok; // [R9] [R10]
                end else begin
                    s_nxt.resend = 1'b1; // [R11] [R12]
                end
            end
        end
        if (!resetn) begin
            s_nxt = '0;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        s_r <= s_nxt;
    end

    // sender drives nothing on status cycles; receivers own them
    assign bus.cycle   = s_r.cycle;
    assign bus.active  = s_r.busy;
    assign bus.is_eoi  = s_r.eoi;
    assign bus.mode    = s_r.mode;
    assign bus.snd_out = 2'h0;
    assign bus.snd_oe  = 2'h0;

    assign busy       = s_r.busy;
    assign done       = s_r.done;
    assign resend     = s_r.resend;
    assign arb_update = s_r.arb_update;
    assign msg_length = s_r.length;

endmodule : status_sender

// [rtl/bus_status_pkg.sv]
// shared constants and types for the interrupt message bus status decode
// assumes both ends run on one sys_clk with a synchronous active-low reset
package bus_status_pkg;

    // ------------------------------------------------------------------
    // delivery modes, as carried in the mode field of a message
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DM_FIXED  = 3'h0,
        DM_LOWEST = 3'h1,
        DM_SMI    = 3'h2,
        DM_NMI    = 3'h4,
        DM_INIT   = 3'h5,
        DM_START  = 3'h6,
        DM_EXTERNAL_CONTROLLER_INTERRUPT = 3'h7
    } delivery_mode_t;

    // ------------------------------------------------------------------
    // message cycle numbers and lengths
    // ------------------------------------------------------------------
    localparam logic [5:0] EOI_CS_CYCLE      = 6'h0C; // checksum status, eoi
    localparam logic [5:0] EOI_ACC_CYCLE     = 6'h0D; // acceptance status, eoi
    localparam logic [5:0] EOI_UPDATE_CYCLE  = 6'h0D;
    localparam logic [5:0] EOI_LENGTH        = 6'h0E;
    localparam logic [5:0] SHORT_CS_CYCLE    = 6'h13;
    localparam logic [5:0] SHORT_ACC_CYCLE   = 6'h14;
    localparam logic [5:0] SHORT_UPDATE_CYCLE = 6'h14;
    localparam logic [5:0] SHORT_LENGTH      = 6'h15;
    localparam logic [5:0] LOWEST_WIN_CYCLE  = 6'h21;
    localparam logic [5:0] LOWEST_LENGTH     = 6'h22;

    // ------------------------------------------------------------------
    // status pair codes
    // ------------------------------------------------------------------
    localparam logic [1:0] ST_OK     = 2'h0;
    localparam logic [1:0] ST_FOCUS  = 2'h2;
    localparam logic [1:0] ST_ACCEPT = 2'h2;
    localparam logic [1:0] ST_RETRY  = 2'h3;
    localparam logic [1:0] ST_ERROR  = 2'h3;

endpackage : bus_status_pkg

// [rtl/status_bus_if.sv]
// two-line status bus joining the sending end and a receiving controller
// assumes the bench resolves the wired-or lines from the enables
`timescale 1ns/1ps
interface status_bus_if;
    logic [5:0] cycle;         // current message cycle, driven by sender
    logic       active;        // message in progress
    logic       is_eoi;        // message is end-of-interrupt
    logic [2:0] mode;          // delivery mode
    logic [1:0] line_in;       // resolved level of both lines
    logic [1:0] snd_out;       // sender line drive
    logic [1:0] snd_oe;        // sender line enable
    logic [1:0] rcv_out;       // receiver line drive
    logic [1:0] rcv_oe;        // receiver line enable

    modport sender   (output cycle, active, is_eoi, mode, snd_out, snd_oe, input line_in);
    modport receiver (input cycle, active, is_eoi, mode, line_in, output rcv_out, rcv_oe);
endinterface : status_bus_if

// [rtl/status_receiver.sv]
// receiving controller: drives checksum, acceptance and win status pairs
// assumes the sender end steps the cycle count on the interface
`timescale 1ns/1ps
module status_receiver (
    input  wire logic    sys_clk,    // 50 MHz clock
    input  wire logic    resetn,     // synchronous reset, active low
    input  wire logic    cs_bad,     // checksum mismatch seen
    input  wire logic    is_focus,   // this is the focus processor
    input  wire logic    can_accept, // free slot available
    input  wire logic    won_arb,    // won lowest-priority arbitration
    status_bus_if.receiver bus,      // status bus
    output logic         ignored     // message disregarded, level
);

    typedef struct packed {
        logic [1:0] out;
        logic [1:0] oe;
        logic       ignored;
    } state_t;

    state_t s_r, s_nxt;
    logic [5:0] nxt_cyc;
    logic       lowest;

    // ------------------------------------------------------------------
    // status drive one cycle ahead so lines are set at the sampled cycle
    // ------------------------------------------------------------------
    always_comb begin
        nxt_cyc = bus.cycle + 6'h01;
        lowest  = !bus.is_eoi && (bus.mode == 3'(bus_status_pkg::DM_LOWEST));
        s_nxt   = s_r;
        s_nxt.oe = 2'h0;
        s_nxt.out = 2'h0;
        if (bus.active) begin
            if (nxt_cyc == (bus.is_eoi ? bus_status_pkg::EOI_CS_CYCLE
                                       : bus_status_pkg::SHORT_CS_CYCLE)) begin
                if (cs_bad) begin
                    s_nxt.out = bus_status_pkg::ST_ERROR; // [R14]
                    s_nxt.oe  = 2'h3;
                    s_nxt.ignored = 1'b1; // [R14]
                end else if (lowest && is_focus) begin
                    s_nxt.out = bus_status_pkg::ST_FOCUS; // [R15]
                    s_nxt.oe  = 2'h3;
                end
            end
            if (nxt_cyc == (bus.is_eoi ? bus_status_pkg::EOI_ACC_CYCLE
                                       : bus_status_pkg::SHORT_ACC_CYCLE) && !s_r.ignored) begin
                // upper line set for both values; lower line 0 on accept, 1 on retry [R1]
                s_nxt.out = can_accept ? bus_status_pkg::ST_ACCEPT : bus_status_pkg::ST_RETRY;
                // no free slot in a no-focus run ends it for a later retry
                if (lowest && !is_focus) begin
                    s_nxt.out = can_accept ? bus_status_pkg::ST_RETRY   // do lowest [R9]
                                           : bus_status_pkg::ST_ACCEPT; // end, retry [R11]
                end
                s_nxt.oe = 2'h3;
            end
            if (nxt_cyc == bus_status_pkg::LOWEST_WIN_CYCLE && won_arb && !s_r.ignored) begin
                s_nxt.out = bus_status_pkg::ST_ACCEPT; // [R16]
                s_nxt.oe  = 2'h3;
            end
        end else begin
            s_nxt.ignored = 1'b0;
        end
        if (!resetn) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        s_r <= s_nxt;
    end

    assign bus.rcv_out = s_r.out;
    assign bus.rcv_oe  = s_r.oe;
    assign ignored     = s_r.ignored;

endmodule : status_receiver

// [verification/status_bus_sva.sv]
// checker for the two-line status bus between sender and receiver ends
// assumes the bench wires it beside the interface, one clock, sync reset
`timescale 1ns/1ps
module status_bus_sva (
    input  wire logic       sys_clk,  // bus clock
    input  wire logic       resetn,   // synchronous reset, active low
    input  wire logic [5:0] cycle,    // message cycle
    input  wire logic       active,   // message in progress
    input  wire logic       is_eoi,   // end-of-interrupt message
    input  wire logic [2:0] mode,     // delivery mode
    input  wire logic [1:0] line_in,  // resolved lines
    input  wire logic [1:0] rcv_oe    // receiver enables
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic lowest;
    logic cs_err_r;
    // lowest-priority runs are the only ones allowed past 21 cycles
    assign lowest = !is_eoi && (mode == bus_status_pkg::DM_LOWEST);
    // remember a failed checksum so the early cut-off can be held to
    always_ff @(posedge sys_clk) begin
        if (!resetn || !active)
            cs_err_r <= 1'b0;
        else if (cycle == bus_status_pkg::SHORT_CS_CYCLE && line_in == 2'h3)
            cs_err_r <= 1'b1;
    end
    chk_eoi_len: assert property (active && is_eoi |-> cycle <= bus_status_pkg::EOI_LENGTH)
        else $error("eoi message ran past its length");
    chk_short_len: assert property (active && !is_eoi && !lowest |->
        cycle <= bus_status_pkg::SHORT_LENGTH) else $error("short message too long");
    chk_lowest_len: assert property (active && lowest |-> cycle <= bus_status_pkg::LOWEST_LENGTH)
        else $error("lowest message too long");
    chk_cs_cutoff: assert property (active && cs_err_r |-> cycle <= bus_status_pkg::SHORT_LENGTH)
        else $error("checksum error did not end message at 21");
    chk_cs_pair: assert property (active && !lowest && cycle == (is_eoi ?
        bus_status_pkg::EOI_CS_CYCLE : bus_status_pkg::SHORT_CS_CYCLE) |->
        line_in[1] == line_in[0]) else $error("checksum pair lines differ");
    chk_rx_slots: assert property (rcv_oe != 2'h0 |-> active &&
        (cycle inside {6'h0C, 6'h0D, 6'h13, 6'h14, 6'h21}))
        else $error("receiver drove outside a status cycle");
    chk_mode_hold: assert property (active && $past(active) |-> $stable(mode) && $stable(is_eoi))
        else $error("mode changed inside a message");
    chk_cycle_step: assert property (active && $past(active) |-> cycle == $past(cycle) + 6'h01)
        else $error("cycle count skipped");
    chk_win_only: assert property (active && cycle == bus_status_pkg::LOWEST_WIN_CYCLE |-> lowest)
        else $error("win cycle reached outside lowest mode");
endmodule : status_bus_sva

// [verification/test_interrupt_bus_status_decode.sv]
// bench for the status decode: sender and receiver joined on one bus
// assumes the rtl package, interface and both ends compile first
`timescale 1ns/1ps
module test_interrupt_bus_status_decode;
    logic       sys_clk = 1'b0;
    logic       resetn = 1'b0;
    logic       start = 1'b0;
    logic       eoi = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [3:0] rx = 4'h0;  // cs_bad, is_focus, can_accept, won_arb
    logic       busy, done, resend, arb_update, ignored;
    logic [5:0] msg_length;
    int         fails = 0;
    int         tests_run = 0;
    int         cyc = 0;
    status_bus_if bus ();
    // wired-or of both ends; an undriven line reads 0
    assign bus.line_in = (bus.snd_out & bus.snd_oe) | (bus.rcv_out & bus.rcv_oe);
    status_sender i_status_sender (.sys_clk(sys_clk), .resetn(resetn), .start(start), .eoi(eoi),
        .mode(mode), .bus(bus), .busy(busy), .done(done), .resend(resend),
        .arb_update(arb_update), .msg_length(msg_length));
    status_receiver i_status_receiver (.sys_clk(sys_clk), .resetn(resetn), .cs_bad(rx[3]),
        .is_focus(rx[2]), .can_accept(rx[1]), .won_arb(rx[0]), .bus(bus), .ignored(ignored));
    status_bus_sva i_status_bus_sva (.sys_clk(sys_clk), .resetn(resetn), .cycle(bus.cycle),
        .active(bus.active), .is_eoi(bus.is_eoi), .mode(bus.mode), .line_in(bus.line_in),
        .rcv_oe(bus.rcv_oe));
    always #10 sys_clk = ~sys_clk;
    // cut a hang short; the full run needs well under 1500 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    // one whole message; start goes out back to back with the last done
    task automatic run(input logic e, input logic [2:0] m, input logic [3:0] r,
                       input logic er, input logic [5:0] el, input logic eu);
        int n;
        int upd;
        eoi = e;
        mode = m;
        rx = r;
        start = 1'b1;
        @(posedge sys_clk);
        #1 start = 1'b0;
        n = 0;
        upd = 0;
        while (done !== 1'b1 && n < 60) begin
            if (arb_update === 1'b1)
                upd++;
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (arb_update === 1'b1)
            upd++;
        tests_run++;
        if (done !== 1'b1 || resend !== er || msg_length !== el || (eu !== 1'bx && upd != eu)
                || busy !== 1'b0 || ignored !== r[3]) begin
            fails++;
            $display("unexpected at %0t: mode %0h resend %b length %0d updates %0d",
                     $time, m, resend, msg_length, upd);
        end
    endtask : run
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 resetn = 1'b1;
        run(1'h1, 3'h0, 4'h2, 1'h0, 6'h0E, 1'h1);
        run(1'h1, 3'h0, 4'h0, 1'h1, 6'h0E, 1'h1);
        run(1'h1, 3'h0, 4'hA, 1'h1, 6'h0E, 1'h0);
        // every short-message mode: accept, retry, checksum error
        for (int k = 0; k < 8; k++) begin
            if (k != 1 && k != 3) begin
                run(1'h0, 3'(k), 4'h2, 1'h0, 6'h15, 1'h1);
                run(1'h0, 3'(k), 4'h0, 1'h1, 6'h15, 1'h1);
                run(1'h0, 3'(k), 4'hA, 1'h1, 6'h15, 1'h0);
            end
        end
        run(1'h0, 3'h1, 4'h6, 1'h0, 6'h22, 1'h1);
        run(1'h0, 3'h1, 4'h3, 1'h0, 6'h22, 1'h1);
        run(1'h0, 3'h1, 4'h2, 1'h1, 6'h22, 1'h1);
        run(1'h0, 3'h1, 4'h0, 1'h1, 6'h22, 1'h1);
        run(1'h0, 3'h1, 4'hA, 1'h1, 6'h15, 1'h0);
        end_sim();
    end
endmodule : test_interrupt_bus_status_decode
